// ---- fsq_flash.sv ----
// Flash controller: unlock, block erase, row program, core stall
//
// Behaviour
// - Program by row; rows reprogram only after erase
// - Software saves eight rows before erasing
// - Row program takes 64 buffered words
// - Operation select 0010 means block erase
// - Erase needs erase and write-enable bits set
// - Select 0001 programs row, erase bit clear
// - Software loads page and base before unlock; the core writes the page only ahead of an erase
// - No operation runs without the unlock
// - Start bit begins erase; core stalled throughout
// - Core stalled until row write finishes
// - Hardware clears start bit on completion
// - Software repeats rows, stepping page, whole block
// - Two idle instructions follow the start
// - Interrupts held for six instructions around start
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "fsq_defines.svh"
module fsq_flash
   import fsq_pkg::*;
#(
   parameter  int BLOCKS        = 2,
   parameter  int ERASE_TIME_NS = `FSQ_ERASE_TIME_NS,
   parameter  int PROG_TIME_NS  = `FSQ_PROG_TIME_NS,
   localparam int WORDS         = BLOCKS * `FSQ_BLOCK_WORDS,
   localparam int AW            = $clog2(WORDS)
) (
   input  wire logic                   CLK,
   input  wire logic                   RESET,
   fsq_if.flash                        BUS,
   input  wire logic [AW-1:0]          FETCH_ADDR,
   output logic      [`FSQ_WORD_W-1:0] FETCH_DATA,
   output logic                        BUSY
);
   // Least times round up to whole cycles, never below the word count
   localparam int ERASE_RAW    = (ERASE_TIME_NS + `FSQ_CLK_PERIOD_NS - 1) / `FSQ_CLK_PERIOD_NS;
   localparam int PROG_RAW     = (PROG_TIME_NS + `FSQ_CLK_PERIOD_NS - 1) / `FSQ_CLK_PERIOD_NS;
   localparam int ERASE_CYCLES = (ERASE_RAW > `FSQ_BLOCK_WORDS) ? ERASE_RAW : `FSQ_BLOCK_WORDS;
   localparam int PROG_CYCLES  = (PROG_RAW > `FSQ_ROW_WORDS) ? PROG_RAW : `FSQ_ROW_WORDS;
   localparam int MAX_CYCLES   = (ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
   localparam int TW           = $clog2(MAX_CYCLES + 1);

   logic [`FSQ_WORD_W-1:0]  mem [WORDS];
   logic [`FSQ_WORD_W-1:0]  row_buf [`FSQ_ROW_WORDS];

   fsq_dev_e                state;
   fsq_key_e                key_state;
   logic [3:0]              ctrl_op;
   logic                    ctrl_erase;
   logic                    ctrl_write_enable;
   logic                    ctrl_start;
   logic                    ctrl_refused;
   logic [15:0]             table_page;
   logic [AW-1:0]           addr_latch;
   logic [TW-1:0]           timer;
   logic [`FSQ_BLOCK_BITS:0] word_cnt;
   logic [15:0]             rdata;

   logic                    idle;
   logic                    any_wr;
   logic                    wr_ctrl;
   logic                    start_req;
   logic                    valid_erase;
   logic                    valid_prog;
   logic                    go;
   logic                    last_cycle;
   logic                    word_left;
   logic [AW-1:0]           wr_addr;
   logic [15:0]             ctrl_word;

   assign idle        = (state == DEV_IDLE);
   assign any_wr      = idle && (BUS.reg_wr || BUS.tbl_wr);
   assign wr_ctrl     = idle && BUS.reg_wr && (BUS.reg_addr == `FSQ_REG_CONTROL);
   assign start_req   = wr_ctrl && BUS.reg_wdata[`FSQ_BIT_START];
   assign valid_erase = (BUS.reg_wdata[`FSQ_OP_MSB:0] == OP_BLOCK_ERASE)
                        && BUS.reg_wdata[`FSQ_BIT_ERASE];
   assign valid_prog  = (BUS.reg_wdata[`FSQ_OP_MSB:0] == OP_ROW_PROGRAM)
                        && !BUS.reg_wdata[`FSQ_BIT_ERASE];
   // Unlock and write enable gate every start
   assign go          = start_req && (key_state == KEY_ARMED)
                        && BUS.reg_wdata[`FSQ_BIT_WRITE_ENABLE]
                        && (valid_erase || valid_prog);

   assign last_cycle  = (state == DEV_ERASE) ? (timer == TW'(ERASE_CYCLES - 1))
                                             : (timer == TW'(PROG_CYCLES - 1));
   assign word_left   = (state == DEV_ERASE) ? (word_cnt < (`FSQ_BLOCK_BITS + 1)'(`FSQ_BLOCK_WORDS))
                                             : (word_cnt < (`FSQ_BLOCK_BITS + 1)'(`FSQ_ROW_WORDS));

   // Erase walks the whole eight-row block, program walks one row
   always_comb begin
      if (state == DEV_ERASE) begin
         wr_addr = {addr_latch[AW-1:`FSQ_BLOCK_BITS],
                    word_cnt[`FSQ_BLOCK_BITS-1:0]};
      end else begin
         wr_addr = {addr_latch[AW-1:`FSQ_ROW_BITS],
                    word_cnt[`FSQ_ROW_BITS-1:0]};
      end
   end

   always_comb begin
      ctrl_word                      = 16'h0000;
      ctrl_word[`FSQ_BIT_START]      = ctrl_start;
      ctrl_word[`FSQ_BIT_WRITE_ENABLE]       = ctrl_write_enable;
      ctrl_word[`FSQ_BIT_REFUSED]    = ctrl_refused;
      ctrl_word[`FSQ_BIT_ERASE]      = ctrl_erase;
      ctrl_word[`FSQ_OP_MSB:0]       = ctrl_op;
   end

   // Key sequence: only consecutive writes count
   always_ff @(posedge CLK) begin
      if (RESET) begin
         key_state <= KEY_IDLE;
      end else if (any_wr) begin
         if (BUS.reg_wr && BUS.reg_addr == `FSQ_REG_KEY && BUS.reg_wdata == `FSQ_KEY_FIRST) begin
            key_state <= KEY_HALF;
         end else if (BUS.reg_wr && BUS.reg_addr == `FSQ_REG_KEY && BUS.reg_wdata == `FSQ_KEY_SECOND
                      && key_state == KEY_HALF) begin
            key_state <= KEY_ARMED;
         end else begin
            key_state <= KEY_IDLE;
         end
      end
   end

   // Control register fields
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_op    <= 4'h0;
         ctrl_erase <= 1'b0;
         ctrl_write_enable  <= 1'b0;
         ctrl_start <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_op    <= BUS.reg_wdata[`FSQ_OP_MSB:0];
         ctrl_erase <= BUS.reg_wdata[`FSQ_BIT_ERASE];
         ctrl_write_enable  <= BUS.reg_wdata[`FSQ_BIT_WRITE_ENABLE];
         ctrl_start <= go;
      end else if (!idle && last_cycle) begin
         ctrl_start <= 1'b0;
      end
   end

   // Refused flag: a new refusal beats a clearing write
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_refused <= 1'b0;
      end else if (start_req && !go) begin
         ctrl_refused <= 1'b1;
      end else if (wr_ctrl) begin
         ctrl_refused <= ctrl_refused & BUS.reg_wdata[`FSQ_BIT_REFUSED];
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         table_page <= 16'h0000;
      end else if (idle && BUS.reg_wr && BUS.reg_addr == `FSQ_REG_PAGE) begin
         table_page <= BUS.reg_wdata;
      end
   end

   // Table writes fill the row buffer and set the target address
   always_ff @(posedge CLK) begin
      if (RESET) begin
         addr_latch <= '0;
      end else if (idle && BUS.tbl_wr) begin
         addr_latch <= AW'({table_page, BUS.tbl_offset[15:1]});
      end
   end

   always_ff @(posedge CLK) begin
      if (idle && BUS.tbl_wr) begin
         row_buf[BUS.tbl_offset[`FSQ_ROW_BITS:1]] <= BUS.tbl_data;
      end
   end

   // Operation sequencer
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state    <= DEV_IDLE;
         timer    <= '0;
         word_cnt <= '0;
      end else begin
         case (state)
            DEV_IDLE: begin
               timer    <= '0;
               word_cnt <= '0;
               if (go && valid_erase) begin
                  state <= DEV_ERASE;
               end else if (go) begin
                  state <= DEV_PROGRAM;
               end
            end
            DEV_ERASE, DEV_PROGRAM: begin
               timer <= timer + TW'(1);
               if (word_left) begin
                  word_cnt <= word_cnt + (`FSQ_BLOCK_BITS + 1)'(1);
               end
               if (last_cycle) begin
                  state <= DEV_IDLE;
               end
            end
            default: begin
               state <= DEV_IDLE;
            end
         endcase
      end
   end

   // Flash array: erase sets words, programming can only clear bits
   always_ff @(posedge CLK) begin
      if (state == DEV_ERASE && word_left) begin
         mem[wr_addr] <= `FSQ_ERASED_WORD;
      end else if (state == DEV_PROGRAM && word_left) begin
         mem[wr_addr] <= mem[wr_addr] & row_buf[word_cnt[`FSQ_ROW_BITS-1:0]];
      end
      FETCH_DATA <= mem[FETCH_ADDR];
   end

   // Register reads answer one cycle later; key reads as zero
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata <= 16'h0000;
      end else if (BUS.reg_rd) begin
         case (BUS.reg_addr)
            `FSQ_REG_CONTROL: rdata <= ctrl_word;
            `FSQ_REG_PAGE:    rdata <= table_page;
            default:          rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   assign BUS.reg_rdata = rdata;
   assign BUS.stall     = !idle;
   assign BUSY          = !idle;
endmodule

// ---- fsq_defines.svh ----
// Shared constants for the flash self-programming sequencer
`ifndef FSQ_DEFINES_SVH
`define FSQ_DEFINES_SVH

`define FSQ_CLK_PERIOD_NS 40
`define FSQ_ERASE_TIME_NS 40000
`define FSQ_PROG_TIME_NS  4000

`define FSQ_ROW_WORDS     64
`define FSQ_ROW_BITS      6
`define FSQ_BLOCK_ROWS    8
`define FSQ_BLOCK_WORDS   512
`define FSQ_BLOCK_BITS    9
`define FSQ_WORD_W        24
`define FSQ_ERASED_WORD   24'hFF_FFFF

`define FSQ_REG_CONTROL   2'h0
`define FSQ_REG_KEY       2'h1
`define FSQ_REG_PAGE      2'h2

`define FSQ_KEY_FIRST     16'h0055
`define FSQ_KEY_SECOND    16'h00AA

`define FSQ_BIT_START     15
`define FSQ_BIT_WRITE_ENABLE      14
`define FSQ_BIT_REFUSED   13
`define FSQ_BIT_ERASE     6
`define FSQ_OP_MSB        3

`define FSQ_HREG_CMD      3'h0
`define FSQ_HREG_PAGE     3'h1
`define FSQ_HREG_OFFSET   3'h2
`define FSQ_HREG_DATA     3'h3
`define FSQ_HREG_CTRL     3'h4
`define FSQ_CMD_ERASE     0
`define FSQ_CMD_PROGRAM   1
`define FSQ_ST_BUSY       0
`define FSQ_ST_REFUSED    1
`define FSQ_ST_DONE       2
`define FSQ_OFFSET_STEP   16'h0002

`endif

// ---- fsq_pkg.sv ----
// Types shared by both ends of the flash sequencer
package fsq_pkg;
   typedef enum logic [3:0] {
      OP_ROW_PROGRAM = 4'h1,
      OP_BLOCK_ERASE = 4'h2
   } fsq_op_e;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_HALF  = 2'b01,
      KEY_ARMED = 2'b10
   } fsq_key_e;

   typedef enum logic [1:0] {
      DEV_IDLE    = 2'b00,
      DEV_ERASE   = 2'b01,
      DEV_PROGRAM = 2'b10
   } fsq_dev_e;

   typedef enum logic [3:0] {
      H_IDLE   = 4'b0000,
      H_CFG    = 4'b0001,
      H_PAGE   = 4'b0010,
      H_BASE   = 4'b0011,
      H_KEY1   = 4'b0100,
      H_KEY2   = 4'b0101,
      H_START  = 4'b0110,
      H_NOP1   = 4'b0111,
      H_NOP2   = 4'b1000,
      H_WAIT   = 4'b1001,
      H_CHECK  = 4'b1010,
      H_RESULT = 4'b1011,
      H_TBL    = 4'b1100
   } fsq_host_e;
endpackage

// ---- fsq_if.sv ----
// Link between the processor core and the flash controller
`timescale 1ns/1ps
interface fsq_if;
   logic [1:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        tbl_wr;
   logic [15:0] tbl_offset;
   logic [23:0] tbl_data;
   logic        stall;

   modport core  (output reg_addr, reg_wdata, reg_wr, reg_rd, tbl_wr, tbl_offset, tbl_data,
                  input  reg_rdata, stall);
   modport flash (input  reg_addr, reg_wdata, reg_wr, reg_rd, tbl_wr, tbl_offset, tbl_data,
                  output reg_rdata, stall);
endinterface

// ---- fsq_core.sv ----
// Core-side sequencer issuing buffer loads, keys and start
`timescale 1ns/1ps
`include "fsq_defines.svh"
module fsq_core
   import fsq_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET,
   fsq_if.core              BUS,
   input  wire logic [2:0]  ADDR,
   input  wire logic [23:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [23:0] RDATA,
   output logic             INT_HOLD
);
   fsq_host_e   state;
   logic        op_erase;
   logic [15:0] page;
   logic [15:0] offset;
   logic [23:0] data_word;
   logic        refused;
   logic        done;
   logic [15:0] ctrl_seen;
   logic [15:0] cfg_word;
   logic        idle;
   logic        user_wr;

   assign idle    = (state == H_IDLE);
   assign user_wr = WR && idle;

   always_comb begin
      cfg_word                   = 16'h0000;
      cfg_word[`FSQ_BIT_WRITE_ENABLE]    = 1'b1;
      cfg_word[`FSQ_BIT_ERASE]   = op_erase;
      cfg_word[`FSQ_OP_MSB:0]    = op_erase ? OP_BLOCK_ERASE : OP_ROW_PROGRAM;
   end

   // Sequencer with registered bus outputs for the next state
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state          <= H_IDLE;
         op_erase       <= 1'b0;
         BUS.reg_wr     <= 1'b0;
         BUS.reg_rd     <= 1'b0;
         BUS.reg_addr   <= 2'h0;
         BUS.reg_wdata  <= 16'h0000;
         BUS.tbl_wr     <= 1'b0;
         BUS.tbl_offset <= 16'h0000;
         BUS.tbl_data   <= 24'h00_0000;
      end else begin
         BUS.reg_wr <= 1'b0;
         BUS.reg_rd <= 1'b0;
         BUS.tbl_wr <= 1'b0;
         case (state)
            H_IDLE: begin
               if (user_wr && ADDR == `FSQ_HREG_CMD &&
                   (WDATA[`FSQ_CMD_ERASE] || WDATA[`FSQ_CMD_PROGRAM])) begin
                  op_erase <= WDATA[`FSQ_CMD_ERASE];
                  state    <= H_CFG;
               end else if (user_wr && ADDR == `FSQ_HREG_DATA) begin
                  BUS.tbl_wr     <= 1'b1;
                  BUS.tbl_offset <= offset;
                  BUS.tbl_data   <= WDATA;
                  state          <= H_TBL;
               end
            end
            H_CFG: begin
               BUS.reg_wr    <= 1'b1;
               BUS.reg_addr  <= `FSQ_REG_CONTROL;
               BUS.reg_wdata <= cfg_word;
               state         <= op_erase ? H_PAGE : H_KEY1;
            end
            H_PAGE: begin
               BUS.reg_wr    <= 1'b1;
               BUS.reg_addr  <= `FSQ_REG_PAGE;
               BUS.reg_wdata <= page;
               state         <= H_BASE;
            end
            H_BASE: begin
               BUS.tbl_wr     <= 1'b1;
               BUS.tbl_offset <= offset;
               BUS.tbl_data   <= data_word;
               state          <= H_KEY1;
            end
            H_KEY1: begin
               BUS.reg_wr    <= 1'b1;
               BUS.reg_addr  <= `FSQ_REG_KEY;
               BUS.reg_wdata <= `FSQ_KEY_FIRST;
               state         <= H_KEY2;
            end
            H_KEY2: begin
               BUS.reg_wr    <= 1'b1;
               BUS.reg_addr  <= `FSQ_REG_KEY;
               BUS.reg_wdata <= `FSQ_KEY_SECOND;
               state         <= H_START;
            end
            H_START: begin
               BUS.reg_wr                         <= 1'b1;
               BUS.reg_addr                       <= `FSQ_REG_CONTROL;
               BUS.reg_wdata                      <= cfg_word;
               BUS.reg_wdata[`FSQ_BIT_START]      <= 1'b1;
               state                              <= H_NOP1;
            end
            H_NOP1: state <= H_NOP2;
            H_NOP2: state <= H_WAIT;
            H_WAIT: begin
               if (!BUS.stall) begin
                  BUS.reg_rd   <= 1'b1;
                  BUS.reg_addr <= `FSQ_REG_CONTROL;
                  state        <= H_CHECK;
               end
            end
            H_CHECK:  state <= H_RESULT;
            H_RESULT: state <= H_IDLE;
            H_TBL:    state <= H_IDLE;
            default:  state <= H_IDLE;
         endcase
      end
   end

   // Page and offset; page steps after each finished row
   always_ff @(posedge CLK) begin
      if (RESET) begin
         page   <= 16'h0000;
         offset <= 16'h0000;
      end else if (user_wr && ADDR == `FSQ_HREG_PAGE) begin
         page <= WDATA[15:0];
      end else if (user_wr && ADDR == `FSQ_HREG_OFFSET) begin
         offset <= WDATA[15:0];
      end else if (state == H_TBL) begin
         offset <= offset + `FSQ_OFFSET_STEP;
      end else if (state == H_RESULT && !op_erase && !BUS.reg_rdata[`FSQ_BIT_START]
                   && !BUS.reg_rdata[`FSQ_BIT_REFUSED]) begin
         page <= page + 16'h0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         data_word <= 24'h00_0000;
      end else if (user_wr && ADDR == `FSQ_HREG_DATA) begin
         data_word <= WDATA;
      end
   end

   // Outcome of the last operation
   always_ff @(posedge CLK) begin
      if (RESET) begin
         refused   <= 1'b0;
         done      <= 1'b0;
         ctrl_seen <= 16'h0000;
      end else if (state == H_CFG) begin
         refused <= 1'b0;
         done    <= 1'b0;
      end else if (state == H_RESULT) begin
         ctrl_seen <= BUS.reg_rdata;
         refused   <= BUS.reg_rdata[`FSQ_BIT_REFUSED];
         done      <= !BUS.reg_rdata[`FSQ_BIT_START] && !BUS.reg_rdata[`FSQ_BIT_REFUSED];
      end
   end

   // Interrupts held across keys, start and the two idle slots
   always_ff @(posedge CLK) begin
      if (RESET) begin
         INT_HOLD <= 1'b0;
      end else begin
         INT_HOLD <= (state == H_KEY1) || (state == H_KEY2) || (state == H_START) || (state == H_NOP1)
                     || (state == H_NOP2) || (state == H_BASE)
                     || (state == H_CFG && !op_erase);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         RDATA <= 24'h00_0000;
      end else if (RD) begin
         case (ADDR)
            `FSQ_HREG_CMD: begin
               RDATA                   <= 24'h00_0000;
               RDATA[`FSQ_ST_BUSY]     <= !idle;
               RDATA[`FSQ_ST_REFUSED]  <= refused;
               RDATA[`FSQ_ST_DONE]     <= done;
            end
            `FSQ_HREG_PAGE:   RDATA <= {8'h00, page};
            `FSQ_HREG_OFFSET: RDATA <= {8'h00, offset};
            `FSQ_HREG_DATA:   RDATA <= data_word;
            `FSQ_HREG_CTRL:   RDATA <= {8'h00, ctrl_seen};
            default:          RDATA <= 24'h00_0000;
         endcase
      end else begin
         RDATA <= 24'h00_0000;
      end
   end
endmodule

// ---- fsq_link_props.sv ----
// Interface checks between core and flash controller
`timescale 1ns/1ps
module fsq_link_props #(
   parameter int ERASE_CYC = 512,
   parameter int PROG_CYC  = 64
) (
   input wire logic        CLK,
   input wire logic        RESET,
   input wire logic [1:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        tbl_wr,
   input wire logic [15:0] tbl_offset,
   input wire logic [23:0] tbl_data,
   input wire logic        stall
);
   logic        key1;
   logic        key2;
   logic        ctl_wr;
   logic        good_op;
   logic        was_erase;
   logic [15:0] stall_cnt;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   assign key1    = reg_wr && !stall && reg_addr == 2'h1 && reg_wdata == 16'h0055;
   assign key2    = reg_wr && !stall && reg_addr == 2'h1 && reg_wdata == 16'h00AA;
   assign ctl_wr  = reg_wr && !stall && reg_addr == 2'h0;
   assign good_op = reg_wdata[14] && (reg_wdata[3:0] == 4'h2 ? reg_wdata[6] : reg_wdata[3:0] == 4'h1 && !reg_wdata[6]);
   // Length of the current stall
   always_ff @(posedge CLK) begin
      if (RESET) stall_cnt <= 16'h0000;
      else if (stall) stall_cnt <= stall_cnt + 16'h0001;
      else stall_cnt <= 16'h0000;
   end
   // Kind of the last start
   always_ff @(posedge CLK) begin
      if (RESET) was_erase <= 1'b0;
      else if (ctl_wr && reg_wdata[15]) was_erase <= reg_wdata[3:0] == 4'h2;
   end
   a_unlock_starts: assert property (ctl_wr && reg_wdata[15] && good_op && $past(key2) && $past(key1, 2) |=> stall)
      else $error("start after unlock did not stall");
   a_stall_has_key: assert property ($rose(stall) |-> $past(ctl_wr && reg_wdata[15] && good_op) && $past(key2, 2)
      && $past(key1, 3))
      else $error("stall without full unlock");
   a_erase_length: assert property ($fell(stall) && was_erase |-> stall_cnt == ERASE_CYC[15:0])
      else $error("erase stall length wrong");
   a_prog_length: assert property ($fell(stall) && !was_erase |-> stall_cnt == PROG_CYC[15:0])
      else $error("program stall length wrong");
   a_start_reads_clear: assert property ($past(reg_rd && !stall && reg_addr == 2'h0) |-> !reg_rdata[15])
      else $error("start bit read as set");
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data without read");
   a_key_order: assert property (key1 |=> key2 ##1 ctl_wr && reg_wdata[15])
      else $error("key pair and start not back to back");
   a_erase_fields: assert property (ctl_wr && reg_wdata[3:0] == 4'h2 |-> reg_wdata[6] && reg_wdata[14])
      else $error("erase word lacks erase or enable bit");
   a_prog_fields: assert property (ctl_wr && reg_wdata[3:0] == 4'h1 |-> !reg_wdata[6] && reg_wdata[14])
      else $error("program word has wrong bits");
   a_core_held: assert property (stall |-> !reg_wr && !reg_rd && !tbl_wr)
      else $error("core active while stalled");
   a_erase_base: assert property (ctl_wr && reg_wdata[15] && reg_wdata[3:0] == 4'h2 |-> $past(tbl_wr, 3)
      && $past(reg_wr && reg_addr == 2'h2, 4))
      else $error("erase without page and base");
endmodule

// ---- tb_flash_block_erase_row_program.sv ----
// Testbench: core and flash joined, plus a flash driven by a rogue core
`timescale 1ns/1ps
module tb_flash_block_erase_row_program;
   logic        clk;
   logic        reset;
   logic [2:0]  addr;
   logic [23:0] wdata;
   logic        wr;
   logic        rd;
   logic [23:0] rdata;
   logic        int_hold;
   logic        busy;
   logic        busy2;
   logic [9:0]  fetch_addr;
   logic [23:0] fetch_data;
   logic [23:0] s0;
   logic [23:0] shadow [1024];
   int          err_total;
   int          tests_run;
   int          busy_cnt;
   int          busy2_cnt;
   int          hold_cnt;
   fsq_if link_if ();
   fsq_if rogue_if ();
   fsq_core fsq_core_i (.CLK(clk), .RESET(reset), .BUS(link_if.core), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .INT_HOLD(int_hold));
   fsq_flash #(.ERASE_TIME_NS(40), .PROG_TIME_NS(40)) fsq_flash_i (.CLK(clk), .RESET(reset),
      .BUS(link_if.flash), .FETCH_ADDR(fetch_addr), .FETCH_DATA(fetch_data), .BUSY(busy));
   fsq_flash #(.ERASE_TIME_NS(40), .PROG_TIME_NS(40)) fsq_flash_rogue_i (.CLK(clk), .RESET(reset),
      .BUS(rogue_if.flash), .FETCH_ADDR(10'h000), .FETCH_DATA(), .BUSY(busy2));
   fsq_link_props fsq_link_props_i (.CLK(clk), .RESET(reset),
      .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata), .reg_wr(link_if.reg_wr),
      .reg_rd(link_if.reg_rd), .reg_rdata(link_if.reg_rdata), .tbl_wr(link_if.tbl_wr),
      .tbl_offset(link_if.tbl_offset), .tbl_data(link_if.tbl_data), .stall(link_if.stall));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (busy) busy_cnt++;
      if (busy2) busy2_cnt++;
      if (int_hold) hold_cnt++;
   end
   task automatic end_sim();
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic uw(input logic [2:0] a, input logic [23:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic ur(input logic [2:0] a, output logic [23:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic bw(input logic [1:0] a, input logic [15:0] d, input logic t);
      @(posedge clk);
      rogue_if.reg_addr <= a;
      rogue_if.reg_wdata <= d;
      rogue_if.tbl_offset <= d;
      rogue_if.tbl_data <= {8'h00, d};
      rogue_if.reg_wr <= !t;
      rogue_if.tbl_wr <= t;
      @(posedge clk);
      rogue_if.reg_wr <= 1'b0;
      rogue_if.tbl_wr <= 1'b0;
   endtask
   task automatic br(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      rogue_if.reg_addr <= a;
      rogue_if.reg_rd <= 1'b1;
      @(posedge clk);
      rogue_if.reg_rd <= 1'b0;
      #1 d = rogue_if.reg_rdata;
   endtask
   task automatic wait_idle(output logic [23:0] s);
      s = 24'h00_0001;
      for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) ur(3'h0, s);
      chk(s & 24'h00_0007, 24'h00_0004);
   endtask
   task automatic fetch_check(input int lo, input int hi);
      for (int a = lo; a < hi; a++) begin
         @(posedge clk);
         fetch_addr <= 10'(a);
         @(posedge clk);
         #1 chk(fetch_data, shadow[a]);
      end
   endtask
   task automatic t_erase();
      logic [23:0] s;
      uw(3'h1, 24'h00_0000);
      uw(3'h2, 24'h00_0000);
      busy_cnt = 0;
      hold_cnt = 0;
      uw(3'h0, 24'h00_0001);
      wait_idle(s);
      chk(24'(busy_cnt), 24'h00_0200);
      chk(24'(hold_cnt), 24'h00_0006);
      ur(3'h4, s);
      chk(s, 24'h00_4042);
      for (int i = 0; i < 512; i++) shadow[i] = 24'hFF_FFFF;
      fetch_check(0, 512);
   endtask
   task automatic t_prog(input logic [23:0] pat, input logic [15:0] page);
      logic [23:0] s;
      uw(3'h2, 24'h00_0080);
      for (int i = 0; i < 64; i++) begin
         uw(3'h3, pat ^ 24'(i));
         repeat (2) @(posedge clk);
         shadow[64 + i] &= pat ^ 24'(i);
      end
      busy_cnt = 0;
      hold_cnt = 0;
      uw(3'h0, 24'h00_0002);
      wait_idle(s);
      chk(24'(busy_cnt), 24'h00_0040);
      chk(24'(hold_cnt), 24'h00_0006);
      ur(3'h4, s);
      chk(s, 24'h00_4001);
      ur(3'h1, s);
      chk(s, {8'h00, page});
      ur(3'h2, s);
      chk(s, 24'h00_0100);
      fetch_check(63, 129);
   endtask
   task automatic t_refuse();
      logic [15:0] d;
      logic [15:0] word [4] = '{16'hC042, 16'hC042, 16'h8042, 16'hC002};
      for (int m = 0; m < 4; m++) begin
         if (m != 0) bw(2'h1, 16'h0055, 1'b0);
         if (m != 0) bw(2'h1, 16'h00AA, 1'b0);
         if (m == 1) bw(2'h0, 16'h0000, 1'b1);
         bw(2'h0, word[m], 1'b0);
         br(2'h0, d);
         chk({8'h00, d & 16'hA000}, 24'h00_2000);
      end
      chk(24'(busy2_cnt), 24'h00_0000);
      br(2'h3, d);
      chk({8'h00, d}, 24'h00_0000);
      bw(2'h2, 16'h1234, 1'b0);
      br(2'h2, d);
      chk({8'h00, d}, 24'h00_1234);
      bw(2'h1, 16'h0055, 1'b0);
      bw(2'h1, 16'h00AA, 1'b0);
      bw(2'h0, 16'hC001, 1'b0);
      repeat (100) @(posedge clk);
      chk(24'(busy2_cnt), 24'h00_0040);
      br(2'h0, d);
      chk({8'h00, d}, 24'h00_4001);
   endtask
   initial begin
      reset = 1'b1;
      addr = 3'h0;
      wdata = 24'h00_0000;
      wr = 1'b0;
      rd = 1'b0;
      fetch_addr = 10'h000;
      rogue_if.reg_addr = 2'h0;
      rogue_if.reg_wdata = 16'h0000;
      rogue_if.reg_wr = 1'b0;
      rogue_if.reg_rd = 1'b0;
      rogue_if.tbl_wr = 1'b0;
      rogue_if.tbl_offset = 16'h0000;
      rogue_if.tbl_data = 24'h00_0000;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      ur(3'h0, s0);
      chk(s0, 24'h00_0000);
      t_erase();
      t_prog(24'hA5_0F3C, 16'h0001);
      // Second pass without erase only clears bits
      t_prog(24'h3C_F0FF, 16'h0002);
      t_refuse();
      end_sim();
   end
   initial begin
      #800000;
      err_total++;
      end_sim();
   end
endmodule
